// File: external_data_move_instruction_router_pkg.sv
// Constants and types shared by the external data move router and its SRAM.
// Assumes a single 20 MHz system clock; no software-visible register bus.
package external_data_move_instruction_router_pkg;

  // ----------------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------------
  localparam int unsigned MC_CLKS     = 4;
  localparam logic [1:0]  PH_FIRST    = 2'h0;
  localparam logic [1:0]  PH_LAST     = 2'h3;
  localparam logic [1:0]  ALE_PH_END  = 2'h1;
  localparam logic [3:0]  STRETCH_MIN = 4'h2;
  localparam logic [3:0]  STRETCH_MAX = 4'h9;
  localparam logic [3:0]  INT_MC      = 4'h2;

  // ----------------------------------------------------------------------
  // Data map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned SRAM_AW     = 10;
  localparam int unsigned SRAM_DEPTH  = 1024;
  localparam logic [15:0] SRAM_TOP    = 16'h03ff;

  // ----------------------------------------------------------------------
  // Reset values and the all-ones output enable mask
  // ----------------------------------------------------------------------
  localparam logic        SRAM_EN_RST = 1'b0;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  OE_ALL      = 8'hff;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_INT} acc_state_e;

endpackage

// File: sram_port_if.sv
// Port between the access sequencer and the on-chip data SRAM.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface sram_port_if;
  import external_data_move_instruction_router_pkg::*;
  logic               en;
  logic               we;
  logic [SRAM_AW-1:0] addr;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: data_sram.sv
// 1 KB single-port data SRAM, one-cycle synchronous read.
// Assumes the controller holds en for one cycle per access.
`timescale 1ns/100ps
`default_nettype none
module data_sram (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  sram_port_if.mem  bus
);
  import external_data_move_instruction_router_pkg::*;

  logic [7:0] mem_q [SRAM_DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (bus.en && bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus.rdata <= BYTE_RST;
    end else if (bus.en && !bus.we) begin
      bus.rdata <= mem_q[bus.addr];
    end
  end
endmodule
`default_nettype wire

// File: external_data_move_instruction_data_memory_router.sv
// Data-memory access path for the external data move instruction.
// Assumes the core issues one request at a time and waits for done_o.
//
// Behaviour
// - Every access is timed in machine cycles of four system clocks.
// - An external access lasts from two to nine machine cycles as software selects.
// - A 1 KB on-chip SRAM at 0000H-03FFH is reached only by data move requests.
// - The on-chip SRAM joins the data map only when its enable bit is set.
// - Reset clears the enable bit so that every address goes to the external bus.
// - Scratchpad accesses never arrive on this path, so they cannot collide with SRAM.
// - The low port drives address/data strongly during external accesses, else acts open-drain.
// - The upper address byte is driven strongly on the second port during external accesses.
// - The write strobe sits on port three bit six and the read strobe on bit seven.
// - With wait control enabled, port four bit zero is an input only.
// - With the SRAM enabled, addresses to 03FFH go inside and higher ones go outside.
`timescale 1ns/100ps
`default_nettype none
module external_data_move_instruction_data_memory_router (
  input  wire logic                          sys_clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          req_i,
  input  wire logic                          we_i,
  input  wire logic [external_data_move_instruction_router_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [7:0]                    wdata_i,
  input  wire logic [2:0]                    stretch_i,
  input  wire logic                          sram_en_wr_i,
  input  wire logic                          sram_en_wdata_i,
  input  wire logic                          wait_en_i,
  input  wire logic [7:0]                    p0_gpio_i,
  input  wire logic [7:0]                    p2_gpio_i,
  input  wire logic                          p40_drive_low_i,
  input  wire logic [7:0]                    p0_i,
  input  wire logic                          port_four_bit_zero_i,
  output logic                               busy_o,
  output logic                               done_o,
  output logic [7:0]                         rdata_o,
  output logic                               sram_en_o,
  output logic [7:0]                         p0_o,
  output logic [7:0]                         p0_oe_o,
  output logic [7:0]                         p2_o,
  output logic                               p2_oe_o,
  output logic                               ale_o,
  output logic                               wr_n_o,
  output logic                               rd_n_o,
  output logic                               port_four_bit_zero_oe_o
);
  import external_data_move_instruction_router_pkg::*;

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  acc_state_e        state_q, state_d;
  logic [1:0]        ph_q, ph_d;
  logic [3:0]        mc_q, mc_d;
  logic [3:0]        len_q;
  logic [15:0]       addr_q;
  logic [7:0]        wdata_q;
  logic              we_q;
  logic              sram_en_q;
  logic              take;
  logic              int_hit;
  logic              end_mc;
  logic              last_mc;
  logic              wait_hold;
  logic              fin;
  logic [15:0]       addr_n;
  logic              ext_d;
  sram_port_if       sram_bus ();

  assign take      = (state_q == ST_IDLE) && req_i;
  assign int_hit   = sram_en_q && (addr_i <= SRAM_TOP);
  assign end_mc    = (ph_q == PH_LAST);
  assign last_mc   = (mc_q == len_q - 4'h1);
  assign wait_hold = wait_en_i && port_four_bit_zero_i;
  assign addr_n    = take ? addr_i : addr_q;
  assign fin       = end_mc && (((state_q == ST_STROBE) && last_mc && !wait_hold) ||
                                ((state_q == ST_INT) && (mc_q == INT_MC - 4'h1)));

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q  <= '0;
      wdata_q <= BYTE_RST;
      we_q    <= 1'b0;
      len_q   <= STRETCH_MIN;
    end else if (take) begin
      addr_q  <= addr_i;
      wdata_q <= wdata_i;
      we_q    <= we_i;
      len_q   <= {1'b0, stretch_i} + STRETCH_MIN;
    end
  end

  // Enable bit of the power management register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sram_en_q <= SRAM_EN_RST;
    end else if (sram_en_wr_i) begin
      sram_en_q <= sram_en_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ph_d    = ph_q + 2'h1;
    mc_d    = mc_q;
    case (state_q)
      ST_IDLE: begin
        ph_d = PH_FIRST;
        mc_d = '0;
        if (req_i) begin
          state_d = int_hit ? ST_INT : ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (end_mc) begin
          mc_d    = mc_q + 4'h1;
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (end_mc) begin
          if (!last_mc) begin
            mc_d = mc_q + 4'h1;
          end else if (!wait_hold) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_INT: begin
        if (end_mc) begin
          mc_d = mc_q + 4'h1;
          if (mc_q == INT_MC - 4'h1) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      ph_q    <= PH_FIRST;
      mc_q    <= '0;
    end else begin
      state_q <= state_d;
      ph_q    <= ph_d;
      mc_q    <= mc_d;
    end
  end

  // ----------------------------------------------------------------------
  // On-chip SRAM, only ever driven by this path
  // ----------------------------------------------------------------------
  assign sram_bus.en    = take && int_hit;
  assign sram_bus.we    = we_i;
  assign sram_bus.addr  = addr_i[SRAM_AW-1:0];
  assign sram_bus.wdata = wdata_i;

  data_sram u_sram (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .bus       (sram_bus.mem)
  );

  // ----------------------------------------------------------------------
  // Core-side answer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      rdata_o   <= BYTE_RST;
      sram_en_o <= SRAM_EN_RST;
    end else begin
      busy_o    <= (state_d != ST_IDLE);
      done_o    <= fin;
      sram_en_o <= sram_en_wr_i ? sram_en_wdata_i : sram_en_q;
      if (fin && !we_q) begin
        rdata_o <= (state_q == ST_INT) ? sram_bus.rdata : p0_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  assign ext_d = (state_d == ST_ADDR) || (state_d == ST_STROBE);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p0_o    <= BYTE_RST;
      p0_oe_o <= '0;
      p2_o    <= BYTE_RST;
      p2_oe_o <= 1'b0;
      ale_o   <= 1'b0;
      wr_n_o  <= 1'b1;
      rd_n_o  <= 1'b1;
      port_four_bit_zero_oe_o <= 1'b0;
    end else begin
      if (state_d == ST_ADDR) begin
        p0_o    <= addr_n[7:0];
        p0_oe_o <= OE_ALL;
      end else if (state_d == ST_STROBE) begin
        p0_o    <= wdata_q;
        p0_oe_o <= we_q ? OE_ALL : '0;
      end else begin
        p0_o    <= BYTE_RST;
        p0_oe_o <= ~p0_gpio_i;
      end
      p2_o    <= ext_d ? addr_n[15:8] : p2_gpio_i;
      p2_oe_o <= ext_d;
      ale_o   <= (state_d == ST_ADDR) && (ph_d <= ALE_PH_END);
      wr_n_o  <= !((state_d == ST_STROBE) && we_q);
      rd_n_o  <= !((state_d == ST_STROBE) && !we_q);
      port_four_bit_zero_oe_o <= !wait_en_i && p40_drive_low_i;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] acc_cnt_q;
  logic       waited_q;
  logic       ext_acc_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_cnt_q <= '0;
      waited_q  <= 1'b0;
      ext_acc_q <= 1'b0;
    end else if (take) begin
      acc_cnt_q <= 8'h01;
      waited_q  <= 1'b0;
      ext_acc_q <= !int_hit;
    end else if (state_q != ST_IDLE) begin
      acc_cnt_q <= acc_cnt_q + 8'h01;
      if (end_mc && last_mc && wait_hold && (state_q == ST_STROBE)) begin
        waited_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_phase_wrap:  assert property ((state_q != ST_IDLE && ph_q == PH_LAST) |=>
    (ph_q == PH_FIRST)) else $error("machine cycle is not four clocks");
  a_ext_length:  assert property ((done_o && ext_acc_q && !waited_q) |->
    (acc_cnt_q == {len_q, 2'b00} + 8'h01)) else $error("external access length wrong");
  a_int_quiet:   assert property ((state_q == ST_INT) |->
    (wr_n_o && rd_n_o && !ale_o && !p2_oe_o)) else $error("internal access drove pins");
  a_reset_route: assert property ((take && !sram_en_q) |=>
    (state_q == ST_ADDR)) else $error("disabled SRAM was routed inside");
  a_sram_route:  assert property ((take && sram_en_q) |=>
    (state_q == ((addr_q <= SRAM_TOP) ? ST_INT : ST_ADDR))) else $error("bad routing");
  a_high_outside: assert property ((take && addr_i > SRAM_TOP) |=> ##4
    (!rd_n_o || !wr_n_o)) else $error("high address not on external bus");
  a_p0_strong:   assert property ((!wr_n_o || ale_o) |->
    (p0_oe_o == OE_ALL)) else $error("low port not driven strongly");
  a_p2_addr:     assert property (ale_o |->
    (p2_oe_o && p2_o == addr_q[15:8])) else $error("upper address missing");
  a_strobe_excl: assert property ((!wr_n_o || !rd_n_o) |->
    ((wr_n_o != rd_n_o) && (wr_n_o == !we_q))) else $error("strobe on wrong pin");
  a_wait_input:  assert property (wait_en_i |=>
    !port_four_bit_zero_oe_o) else $error("wait pin driven while enabled");
  a_wait_hold:   assert property ((state_q == ST_STROBE && end_mc && last_mc && wait_hold) |=>
    (busy_o && (!wr_n_o || !rd_n_o))[*4]) else $error("strobe dropped during wait");

  c_ext_read:  cover property (done_o && ext_acc_q && !we_q);
  c_ext_wait:  cover property (done_o && ext_acc_q && we_q && waited_q);
  c_int_read:  cover property (done_o && !ext_acc_q && !we_q);
  c_long_acc:  cover property (take && stretch_i == 3'h7);
endmodule
`default_nettype wire

// File: ext_mem_model.sv
// Behavioural external data RAM on the multiplexed address/data bus.
// Assumes the bench resolves the low-port and wait wires from all drivers.
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [3:0] wait_clks_i,
  output logic      [7:0] ad_o,
  output logic            wait_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0]  last_q = 8'h5a;
  logic [3:0]  cnt_q = 4'h0;
  logic        strb;

  assign strb = !wr_n_i || !rd_n_i;
  always @(posedge clk_i) begin
    if (ale_i) addr_q <= {hi_i, ad_i};
    if (!wr_n_i) mem[addr_q] <= ad_i;
    if (!rd_n_i) last_q <= ad_o;
    cnt_q <= strb ? cnt_q + 4'h1 : 4'h0;
  end
  // Released bus shows the inverse of the last value, not a stale copy
  assign ad_o = !rd_n_i ? mem[addr_q] : ~last_q;
  // Wait held from strobe start for the asked number of clocks
  assign wait_o = strb && (cnt_q < wait_clks_i);
endmodule
`default_nettype wire

// File: test_external_data_move_instruction_data_memory_router.sv
// Self-checking bench for the external data move router.
// Assumes the design package and the external memory model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_external_data_move_instruction_data_memory_router;
  import external_data_move_instruction_router_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, req = 1'b0, we = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, gp0 = 8'h3c, gp2 = 8'h96;
  logic [2:0]  stretch = 3'h0;
  logic        sram_wr = 1'b0, sram_wd = 1'b0, wait_en = 1'b0, p40_low = 1'b0;
  logic [3:0]  wait_clks = 4'h0;
  logic        busy, done, sram_en, p2_oe, ale, wr_n, rd_n, p40_oe, wt, al;
  logic [7:0]  rdata, p0, p0_oe, p2, ad, p0_in, rd;
  int          num_errors = 0, compares = 0, n, sc, bad;

  always #25 clk = ~clk;
  assign p0_in = (p0_oe & p0) | (~p0_oe & ad);

  external_data_move_instruction_data_memory_router u_dut (.sys_clk_i(clk), .arst_n_i(arst_n), .req_i(req),
    .we_i(we), .addr_i(addr), .wdata_i(wdata), .stretch_i(stretch),
    .sram_en_wr_i(sram_wr), .sram_en_wdata_i(sram_wd), .wait_en_i(wait_en),
    .p0_gpio_i(gp0), .p2_gpio_i(gp2), .p40_drive_low_i(p40_low), .p0_i(p0_in),
    .port_four_bit_zero_i(p40_oe ? 1'b0 : wt), .busy_o(busy), .done_o(done),
    .rdata_o(rdata), .sram_en_o(sram_en), .p0_o(p0), .p0_oe_o(p0_oe), .p2_o(p2),
    .p2_oe_o(p2_oe), .ale_o(ale), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .port_four_bit_zero_oe_o(p40_oe));

  ext_mem_model u_mem (.clk_i(clk), .ale_i(ale), .ad_i(p0), .hi_i(p2), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .wait_clks_i(wait_clks), .ad_o(ad), .wait_o(wt));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One access; counts cycles to done, strobe cycles and pin faults
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [2:0] s);
    logic on;
    @(posedge clk);
    req <= 1'b1; we <= w; addr <= a; wdata <= d; stretch <= s;
    @(posedge clk);
    req <= 1'b0;
    n = 0; sc = 0; bad = 0;
    do begin
      @(posedge clk); #1; n++;
      on = !(w ? wr_n : rd_n);
      if (n == 1) al = ale;
      if (n == 1 && ale && (p0 !== a[7:0] || p2 !== a[15:8] || p0_oe !== 8'hff || !p2_oe))
        bad++;
      if (on) sc++;
      if (!(w ? rd_n : wr_n) || (on && p0_oe !== (w ? 8'hff : 8'h00))) bad++;
      if (on && w && p0 !== d) bad++;
      if (busy !== !done) bad++;
    end while (!done && n < 100);
    rd = rdata;
  endtask

  task automatic set_sram(input logic v);
    @(posedge clk);
    sram_wr <= 1'b1; sram_wd <= v;
    @(posedge clk);
    sram_wr <= 1'b0;
    @(posedge clk); #1;
    chk("sram_en", {15'h0, v}, {15'h0, sram_en});
  endtask

  task automatic t_reset;
    chk("sram_en", 16'h0, {15'h0, sram_en});
    chk("strobes", 16'h3, {14'h0, wr_n, rd_n});
    chk("p0_oe", {8'h0, ~gp0}, {8'h0, p0_oe});
    chk("p2", {8'h0, gp2}, {7'h0, p2_oe, p2});
    $display("test reset done");
  endtask

  task automatic t_ext;
    for (int s = 0; s < 8; s++) begin
      for (int w = 1; w >= 0; w--) begin
        acc(w[0], 16'h0010 + 16'(s), {5'h15, 3'(s)}, 3'(s));
        chk("cycles", 16'((s + 2) * MC_CLKS), 16'(n));
        chk("strobe", 16'((s + 1) * MC_CLKS), 16'(sc));
        chk("pins", 16'h3, {14'h0, bad == 0, al});
        if (w == 0) chk("rdata", {11'h0, 5'h15, 3'(s)}, {8'h0, rd});
      end
    end
    $display("test external done");
  endtask

  logic [15:0] addr_tab [3] = '{16'h0000, 16'h03ff, 16'h0400};

  task automatic t_sram;
    set_sram(1'b1);
    foreach (addr_tab[i]) begin
      acc(1'b1, addr_tab[i], 8'h5c ^ 8'(i), 3'h7);
      acc(1'b0, addr_tab[i], 8'h00, 3'h7);
      chk("rdata", {8'h0, 8'h5c ^ 8'(i)}, {8'h0, rd});
      chk("cycles", 16'(i == 2 ? 9 * MC_CLKS : INT_MC * MC_CLKS), 16'(n));
      chk("strobe", 16'(i == 2 ? 8 * MC_CLKS : 0), 16'(sc));
      chk("pins", {14'h0, 1'b1, i == 2}, {14'h0, bad == 0, al});
    end
    acc(1'b1, 16'h0010, 8'h77, 3'h0);
    set_sram(1'b0);
    acc(1'b0, 16'h0010, 8'h00, 3'h0);
    chk("rdata", 16'h00a8, {8'h0, rd});
    $display("test sram done");
  endtask

  task automatic t_wait;
    @(posedge clk);
    wait_en <= 1'b1; p40_low <= 1'b1; wait_clks <= 4'h6;
    repeat (2) @(posedge clk);
    #1 chk("p40_oe", 16'h0, {15'h0, p40_oe});
    acc(1'b0, 16'h0011, 8'h00, 3'h0);
    chk("cycles", 16'(3 * MC_CLKS), 16'(n));
    chk("strobe", 16'(2 * MC_CLKS), 16'(sc));
    chk("rdata", 16'h00a9, {8'h0, rd});
    @(posedge clk);
    wait_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("p40_oe", 16'h1, {15'h0, p40_oe});
    @(posedge clk);
    p40_low <= 1'b0;
    acc(1'b1, 16'h0012, 8'h3e, 3'h0);
    chk("cycles", 16'(2 * MC_CLKS), 16'(n));
    @(posedge clk);
    wait_clks <= 4'h0;
    $display("test wait done");
  endtask

  task automatic t_b2b;
    int first, cnt;
    set_sram(1'b1);
    first = 0; cnt = 0;
    @(posedge clk);
    req <= 1'b1; we <= 1'b0; addr <= 16'h0000;
    for (int k = 1; k <= 29; k++) begin
      @(posedge clk); #1;
      if (done) begin
        cnt++;
        if (first == 0) first = k;
      end
    end
    @(posedge clk);
    req <= 1'b0;
    repeat (12) @(posedge clk);
    chk("first", 16'(INT_MC * MC_CLKS + 1), 16'(first));
    chk("count", 16'h3, 16'(cnt));
    $display("test back to back done");
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk); #1;
    t_reset();
    t_ext();
    t_sram();
    t_wait();
    t_b2b();
    end_sim();
  end
endmodule
`default_nettype wire
